/* verilog/dbg_cmd_device.sv */
`timescale 1ns/1ps
module dbg_cmd_device (
    input wire logic sys_clk,
    input wire logic srst,
    dbg_link_if.device link,
    input wire logic debug_mode,
    input wire logic read_protect,
    output logic [dbg_cmd_pkg::PROG_ADDR_W-1:0] prog_addr,
    input wire logic [7:0] prog_rdata,
    output logic [15:0] data_addr,
    output logic [7:0] data_wdata,
    output logic data_we,
    input wire logic [7:0] data_rdata,
    output logic step_req,
    input wire logic step_done
);
    import dbg_cmd_pkg::*;

    state_t state_reg;
    logic [7:0] cmd_reg;
    logic [1:0] hdr_idx_reg;
    logic [15:0] addr_reg;
    logic [15:0] size_reg;
    logic [16:0] count_reg;
    logic [15:0] crc_reg;
    logic [PROG_ADDR_W:0] crc_idx_reg;
    logic rd_pend_reg;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    logic rx_take;
    logic allowed;
    logic step_busy_reg;
    logic crc_feed_reg;
    logic [15:0] wr_addr_reg;

    // ****************************************
    // Reply path through the FIFO
    // ****************************************
    byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) reply_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(link.d2h_data),
        .out_valid(link.d2h_valid),
        .out_ready(link.d2h_ready)
    );

    assign allowed = debug_mode && !read_protect;
    assign link.h2d_ready = (state_reg == ST_IDLE) || (state_reg == ST_HDR)
        || (state_reg == ST_WDATA);
    assign rx_take = link.h2d_valid && link.h2d_ready;

    // ****************************************
    // Reply byte source
    // ****************************************
    always_comb begin
        tx_valid = 1'b0;
        tx_data = 8'h00;
        case (state_reg)
            ST_RDATA: begin
                tx_valid = rd_pend_reg;
                if (cmd_reg == CMD_READ_PROG) begin
                    tx_data = prog_rdata;
                end else if (debug_mode) begin
                    tx_data = data_rdata;
                end else begin
                    tx_data = BLANK_BYTE;
                end
            end
            ST_CRC_HI: begin
                tx_valid = 1'b1;
                tx_data = debug_mode ? crc_reg[15:8] : BLANK_CRC[15:8];
            end
            ST_CRC_LO: begin
                tx_valid = 1'b1;
                tx_data = debug_mode ? crc_reg[7:0] : BLANK_CRC[7:0];
            end
            default: begin
                tx_valid = 1'b0;
            end
        endcase
    end

    assign prog_addr = (state_reg == ST_CRC) ? crc_idx_reg[PROG_ADDR_W-1:0]
        : addr_reg[PROG_ADDR_W-1:0];
    // Write strobe trails the address step by one cycle, so it carries its own address
    assign data_addr = data_we ? wr_addr_reg : addr_reg;

    // ****************************************
    // Command sequencer
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            cmd_reg <= 8'h00;
            hdr_idx_reg <= 2'h0;
            addr_reg <= RESET_ADDR;
            size_reg <= 16'h0000;
            count_reg <= RESET_COUNT;
            rd_pend_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (rx_take) begin
                        cmd_reg <= link.h2d_data;
                        hdr_idx_reg <= 2'h0;
                        case (link.h2d_data)
                            CMD_READ_PROG, CMD_WRITE_DATA, CMD_READ_DATA: begin
                                state_reg <= ST_HDR;
                            end
                            CMD_READ_CRC: begin
                                state_reg <= ST_CRC;
                            end
                            CMD_STEP: begin
                                if (allowed) begin
                                    state_reg <= ST_STEP;
                                end
                            end
                            default: begin
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_HDR: begin
                    if (rx_take) begin
                        hdr_idx_reg <= hdr_idx_reg + 2'h1;
                        case (hdr_idx_reg)
                            2'h0: addr_reg[15:8] <= link.h2d_data;
                            2'h1: addr_reg[7:0] <= link.h2d_data;
                            2'h2: size_reg[15:8] <= link.h2d_data;
                            default: begin
                                // Size zero is a full 64K transfer
                                count_reg <= ({size_reg[15:8], link.h2d_data} == 16'h0000)
                                    ? FULL_COUNT : {1'b0, size_reg[15:8], link.h2d_data};
                                state_reg <= (cmd_reg == CMD_WRITE_DATA) ? ST_WDATA : ST_RDATA;
                                rd_pend_reg <= 1'b0;
                            end
                        endcase
                    end
                end
                ST_WDATA: begin
                    if (rx_take) begin
                        addr_reg <= addr_reg + 16'h0001;
                        count_reg <= count_reg - 17'h00001;
                        if (count_reg == 17'h00001) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_RDATA: begin
                    // Memory answers one cycle after the address settles
                    if (!rd_pend_reg) begin
                        rd_pend_reg <= 1'b1;
                    end else if (tx_ready) begin
                        rd_pend_reg <= 1'b0;
                        addr_reg <= addr_reg + 16'h0001;
                        count_reg <= count_reg - 17'h00001;
                        if (count_reg == 17'h00001) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_CRC: begin
                    if (crc_idx_reg[PROG_ADDR_W]) begin
                        state_reg <= ST_CRC_HI;
                    end
                end
                ST_CRC_HI: begin
                    if (tx_ready) begin
                        state_reg <= ST_CRC_LO;
                    end
                end
                ST_CRC_LO: begin
                    if (tx_ready) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_STEP: begin
                    if (step_busy_reg && step_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Data memory write strobe
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            data_we <= 1'b0;
            data_wdata <= 8'h00;
            wr_addr_reg <= RESET_ADDR;
        end else begin
            data_we <= 1'b0;
            if (state_reg == ST_WDATA && rx_take && allowed) begin
                data_we <= 1'b1;
                data_wdata <= link.h2d_data;
                wr_addr_reg <= addr_reg;
            end
        end
    end

    // ****************************************
    // CRC over whole program memory, one byte a cycle
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (srst || state_reg == ST_IDLE) begin
            crc_reg <= CRC_SEED;
            crc_idx_reg <= '0;
            crc_feed_reg <= 1'b0;
        end else if (state_reg == ST_CRC) begin
            // Memory answers one cycle after the address, so data trails the index
            crc_feed_reg <= !crc_idx_reg[PROG_ADDR_W];
            if (!crc_idx_reg[PROG_ADDR_W]) begin
                crc_idx_reg <= crc_idx_reg + 1'b1;
            end
            if (crc_feed_reg) begin
                crc_reg <= crc_byte(crc_reg, prog_rdata);
            end
        end
    end

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // ****************************************
    // Single step request
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            step_req <= 1'b0;
            step_busy_reg <= 1'b0;
        end else begin
            step_req <= 1'b0;
            if (state_reg == ST_STEP && !step_busy_reg) begin
                step_req <= 1'b1;
                step_busy_reg <= 1'b1;
            end else if (state_reg != ST_STEP) begin
                step_busy_reg <= 1'b0;
            end
        end
    end
endmodule // dbg_cmd_device

/* shared/dbg_cmd_pkg.sv */
package dbg_cmd_pkg;
    localparam logic [7:0] CMD_READ_PROG = 8'h0B;
    localparam logic [7:0] CMD_WRITE_DATA = 8'h0C;
    localparam logic [7:0] CMD_READ_DATA = 8'h0D;
    localparam logic [7:0] CMD_READ_CRC = 8'h0E;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] BLANK_BYTE = 8'hFF;
    localparam logic [15:0] BLANK_CRC = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_SEED = 16'hFFFF;
    localparam int PROG_ADDR_W = 13;
    localparam logic [16:0] FULL_COUNT = 17'h10000;
    localparam int FIFO_DEPTH = 16;
    localparam int BYTE_W = 8;
    localparam logic [15:0] RESET_ADDR = 16'h0000;
    localparam logic [16:0] RESET_COUNT = 17'h00000;
    typedef enum {ST_IDLE, ST_HDR, ST_WDATA, ST_RDATA, ST_CRC, ST_CRC_HI, ST_CRC_LO,
        ST_STEP} state_t;
endpackage

/* shared/dbg_link_if.sv */
`timescale 1ns/1ps
interface dbg_link_if;
    logic [7:0] h2d_data;
    logic h2d_valid;
    logic h2d_ready;
    logic [7:0] d2h_data;
    logic d2h_valid;
    logic d2h_ready;
    modport device (input h2d_data, input h2d_valid, output h2d_ready,
        output d2h_data, output d2h_valid, input d2h_ready);
    modport host (output h2d_data, output h2d_valid, input h2d_ready,
        input d2h_data, input d2h_valid, output d2h_ready);
endinterface

/* verilog/byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic push;
    logic pop;

    assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign out_data = mem[rd_reg[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule // byte_fifo

/* verilog/dbg_cmd_host.sv */
`timescale 1ns/1ps
module dbg_cmd_host (
    input wire logic sys_clk,
    input wire logic srst,
    dbg_link_if.host link,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_valid,
    output logic cmd_ready,
    output logic [7:0] rsp_byte,
    output logic rsp_valid,
    input wire logic rsp_ready
);
    import dbg_cmd_pkg::*;

    // ****************************************
    // Command bytes pass straight through, replies through one register stage; host must wait for CRC delay
    // ****************************************
    assign link.h2d_data = cmd_byte;
    assign link.h2d_valid = cmd_valid;
    assign cmd_ready = link.h2d_ready;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rsp_byte <= 8'h00;
            rsp_valid <= 1'b0;
        end else if (!rsp_valid || rsp_ready) begin
            rsp_valid <= link.d2h_valid;
            rsp_byte <= link.d2h_data;
        end
    end

    assign link.d2h_ready = !rsp_valid || rsp_ready;
endmodule // dbg_cmd_host

/* tb/dbg_cmd_chk.sv */
`timescale 1ns/1ps
// ********************************
// Link checker
// ********************************
module dbg_cmd_chk (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] h2d_data,
    input wire logic h2d_valid,
    input wire logic h2d_ready,
    input wire logic [7:0] d2h_data,
    input wire logic d2h_valid,
    input wire logic d2h_ready
);
    import dbg_cmd_pkg::*;
    localparam int CRC_MIN = 2 ** PROG_ADDR_W - 2;
    localparam int CRC_MAX = 2 ** PROG_ADDR_W + 8;
    logic h2d_fire;
    logic d2h_fire;
    logic op_slot;
    logic [2:0] hdr_reg;
    logic [7:0] op_reg;
    logic [7:0] hi_reg;
    logic [16:0] wleft_reg;
    logic [16:0] rleft_reg;
    logic [16:0] size_cnt;
    logic [16:0] add_cnt;
    logic crc_wait_reg;
    logic [15:0] crc_cnt_reg;
    assign h2d_fire = h2d_valid && h2d_ready;
    assign d2h_fire = d2h_valid && d2h_ready;
    assign op_slot = hdr_reg == 3'h0 && wleft_reg == 17'h00000;
    assign size_cnt = {hi_reg, h2d_data} == 16'h0000 ? FULL_COUNT : {1'b0, hi_reg, h2d_data};
    assign add_cnt = !h2d_fire ? 17'h00000 : (op_slot && h2d_data == CMD_READ_CRC) ? 17'h00002 :
        (hdr_reg == 3'h1 && op_reg != CMD_WRITE_DATA) ? size_cnt : 17'h00000;
    // Tracks header position and write payload length
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hdr_reg <= 3'h0;
            op_reg <= 8'h00;
            hi_reg <= 8'h00;
            wleft_reg <= 17'h00000;
        end else if (h2d_fire && wleft_reg != 17'h00000) begin
            wleft_reg <= wleft_reg - 17'h00001;
        end else if (h2d_fire && hdr_reg != 3'h0) begin
            hdr_reg <= hdr_reg - 3'h1;
            hi_reg <= h2d_data;
            if (hdr_reg == 3'h1 && op_reg == CMD_WRITE_DATA) wleft_reg <= size_cnt;
        end else if (h2d_fire && h2d_data inside {CMD_READ_PROG, CMD_WRITE_DATA, CMD_READ_DATA}) begin
            op_reg <= h2d_data;
            hdr_reg <= 3'h4;
        end
    end
    // Bytes the device still owes the host
    always_ff @(posedge sys_clk) begin
        if (srst) rleft_reg <= 17'h00000;
        else rleft_reg <= rleft_reg + add_cnt - {16'h0000, d2h_fire};
    end
    always_ff @(posedge sys_clk) begin
        if (srst || d2h_valid) begin
            crc_wait_reg <= 1'b0;
            crc_cnt_reg <= 16'h0000;
        end else if (h2d_fire && op_slot && h2d_data == CMD_READ_CRC) begin
            crc_wait_reg <= 1'b1;
        end else if (crc_wait_reg) begin
            crc_cnt_reg <= crc_cnt_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_d2h_hold;
        d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data);
    endproperty
    a_d2h_hold: assert property (p_d2h_hold) else $error("d2h byte dropped");
    property p_h2d_hold;
        h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data);
    endproperty
    a_h2d_hold: assert property (p_h2d_hold) else $error("h2d byte dropped");
    property p_reset_ready;
        $past(srst) |-> h2d_ready;
    endproperty
    a_reset_ready: assert property (p_reset_ready) else $error("not idle after reset");
    property p_rsp_count;
        d2h_fire |-> rleft_reg != 17'h00000;
    endproperty
    a_rsp_count: assert property (p_rsp_count) else $error("extra reply byte");
    property p_rd_busy;
        h2d_fire && hdr_reg == 3'h1 && op_reg != CMD_WRITE_DATA |=> !h2d_ready;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("ready during read");
    property p_crc_busy;
        h2d_fire && op_slot && h2d_data == CMD_READ_CRC |=> !h2d_ready [*8];
    endproperty
    a_crc_busy: assert property (p_crc_busy) else $error("ready during crc");
    property p_crc_early;
        crc_wait_reg && d2h_valid |-> crc_cnt_reg >= CRC_MIN;
    endproperty
    a_crc_early: assert property (p_crc_early) else $error("crc too early");
    property p_crc_late;
        crc_wait_reg |-> crc_cnt_reg <= CRC_MAX;
    endproperty
    a_crc_late: assert property (p_crc_late) else $error("crc too late");
endmodule // dbg_cmd_chk

/* tb/debug_memory_command_handler_tb_top.sv */
`timescale 1ns/1ps
module debug_memory_command_handler_tb_top;
    import dbg_cmd_pkg::*;
    logic sys_clk, srst, debug_mode, read_protect, data_we, step_req, step_done;
    logic [PROG_ADDR_W-1:0] prog_addr;
    logic [7:0] prog_rdata, data_wdata, data_rdata, cmd_byte, rsp_byte;
    logic [15:0] data_addr;
    logic cmd_valid, cmd_ready, rsp_valid, rsp_ready;
    logic [7:0] dmem [0:65535];
    logic [7:0] emem [0:65535];
    logic [31:0] seed;
    int miscompares, comparisons;
    int we_cnt = 0;
    int step_cnt = 0;
    dbg_link_if link ();
    dbg_cmd_host dbg_cmd_host_i (.sys_clk(sys_clk), .srst(srst), .link(link),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .rsp_byte(rsp_byte), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));
    dbg_cmd_device dbg_cmd_device_i (.sys_clk(sys_clk), .srst(srst), .link(link),
        .debug_mode(debug_mode), .read_protect(read_protect), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata), .data_addr(data_addr), .data_wdata(data_wdata),
        .data_we(data_we), .data_rdata(data_rdata), .step_req(step_req), .step_done(step_done));
    dbg_cmd_chk dbg_cmd_chk_i (.sys_clk(sys_clk), .srst(srst), .h2d_data(link.h2d_data),
        .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready), .d2h_data(link.d2h_data),
        .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready));
    // ********************************
    // Memories and CPU stand-in
    // ********************************
    always @(posedge sys_clk) begin
        prog_rdata <= prog_byte(prog_addr);
        data_rdata <= dmem[data_addr];
        step_done <= step_req;
        if (data_we === 1'b1) dmem[data_addr] <= data_wdata;
        if (data_we === 1'b1) we_cnt <= we_cnt + 1;
        if (step_req === 1'b1) step_cnt <= step_cnt + 1;
    end
    function automatic logic [7:0] prog_byte(input logic [12:0] a);
        return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5A;
    endfunction
    function automatic logic [7:0] rnd8();
        seed = {seed[30:0], ^(seed & 32'h80200003)};
        return seed[7:0];
    endfunction
    function automatic logic [15:0] crc_exp();
        logic [15:0] c;
        c = CRC_SEED;
        for (int i = 0; i < 2 ** PROG_ADDR_W; i++) begin
            c = c ^ {prog_byte(13'(i)), 8'h00};
            for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction
    task automatic check(input logic [16:0] seen, input logic [16:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic put(input logic [7:0] b);
        cmd_byte = b;
        cmd_valid = 1'b1;
        for (int n = 0; n < 20000 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic get(output logic [7:0] b);
        rsp_ready = 1'b1;
        for (int n = 0; n < 20000 && rsp_valid !== 1'b1; n++) @(negedge sys_clk);
        b = rsp_byte;
        @(negedge sys_clk);
    endtask
    task automatic xfer(input logic [7:0] op, input logic [15:0] a, input int n, input int stall);
        logic [7:0] b;
        put(op);
        if (op != CMD_STEP) begin
            put(a[15:8]);
            put(a[7:0]);
            put(n[15:8]);
            put(n[7:0]);
        end
        for (int i = 0; i < n && op == CMD_WRITE_DATA; i++) begin
            b = rnd8();
            put(b);
            if (debug_mode && !read_protect) emem[16'(a + i)] = b;
        end
        cmd_valid = 1'b0;
        if (stall > 0) begin
            rsp_ready = 1'b0;
            repeat (stall) @(negedge sys_clk);
        end
        for (int i = 0; i < n && op != CMD_WRITE_DATA && op != CMD_STEP; i++) begin
            get(b);
            if (op == CMD_READ_PROG) check(b, prog_byte(13'(a + i)), "prog");
            else check(b, debug_mode ? emem[16'(a + i)] : BLANK_BYTE, "data");
        end
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (97000) @(posedge sys_clk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        logic [15:0] a;
        logic [7:0] hi, lo;
        int n, w, s;
        {srst, debug_mode, read_protect, cmd_valid, rsp_ready} = 5'h18;
        cmd_byte = 8'h00;
        {miscompares, comparisons} = '0;
        seed = 32'h693EED5B;
        for (int i = 0; i < 65536; i++) {dmem[i], emem[i]} = {2{8'(i)}};
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
        xfer(CMD_READ_PROG, 16'h1FFE, 4, 0);
        for (int r = 0; r < 6; r++) begin
            a = {rnd8(), rnd8()};
            n = 1 + rnd8() % 8;
            xfer(CMD_WRITE_DATA, a, n, 0);
            xfer(CMD_READ_DATA, a, n, r);
            xfer(CMD_READ_PROG, a, n, 0);
        end
        xfer(CMD_READ_DATA, 16'h0040, 24, 60);
        for (int m = 0; m < 3; m++) begin
            debug_mode = m != 1;
            read_protect = m == 2;
            w = we_cnt;
            s = step_cnt;
            xfer(CMD_WRITE_DATA, 16'h0200, 3, 0);
            check(17'(we_cnt - w), (m == 0) ? 17'h3 : 17'h0, "we");
            xfer(CMD_READ_DATA, 16'h0200, 3, 0);
            xfer(CMD_STEP, 16'h0000, 0, 0);
            check(17'(step_cnt - s), (m == 0) ? 17'h1 : 17'h0, "step");
            put(CMD_READ_CRC);
            cmd_valid = 1'b0;
            get(hi);
            get(lo);
            check({hi, lo}, (m == 1) ? BLANK_CRC : crc_exp(), "crc");
        end
        debug_mode = 1'b1;
        read_protect = 1'b0;
        w = we_cnt;
        xfer(CMD_WRITE_DATA, 16'h0100, 65536, 0);
        check(17'(we_cnt - w), FULL_COUNT, "full");
        // Unknown opcode must be dropped without disturbing the next command
        w = we_cnt;
        put(8'h55);
        cmd_valid = 1'b0;
        repeat (4) @(negedge sys_clk);
        check(17'(we_cnt - w), 17'h0, "unknown");
        xfer(CMD_READ_DATA, 16'h00FE, 4, 0);
        report_and_stop();
    end
endmodule // debug_memory_command_handler_tb_top
